// file: pkg/acp_consts.svh
/*
 * constants of the ascii command parser: character codes, defaults,
 * line rates, reply lengths.
 * assumes a 7-bit character path and a single device clock.
 */
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH
// ****************************************
// character codes
// ****************************************
`define ACP_CH_ATTN 7'h23
`define ACP_CH_WILD 7'h2A
`define ACP_CH_CR 7'h0D
`define ACP_CH_LF 7'h0A
`define ACP_CH_EQ 7'h3D
`define ACP_CH_SP 7'h20
`define ACP_CH_ZERO 7'h30
`define ACP_CH_NINE 7'h39
`define ACP_CASE_POS 5
`define ACP_CMD_ADR0 7'h41
`define ACP_CMD_ADR1 7'h44
`define ACP_CMD_LRT0 7'h42
`define ACP_CMD_LRT1 7'h52
`define ACP_CMD_ERR0 7'h45
`define ACP_CMD_ERR1 7'h52
// ****************************************
// defaults and ranges
// ****************************************
`define ACP_ADDR_MIN 17'h00001
`define ACP_ADDR_MAX 17'h00063
`define ACP_ADDR_RST 7'h01
`define ACP_RATE_RST 3'h4
`define ACP_RATE_N 3'h6
`define ACP_RATE0 17'h004B0
`define ACP_RATE1 17'h00960
`define ACP_RATE2 17'h012C0
`define ACP_RATE3 17'h02580
`define ACP_RATE4 17'h04B00
`define ACP_RATE5 17'h09600
`define ACP_CLK_HZ 125000000
// ****************************************
// reply and frame sizes
// ****************************************
`define ACP_LEN_ADR 4'h7
`define ACP_LEN_LRT 4'hB
`define ACP_LEN_ERR 4'h4
`define ACP_RB_N 11
`define ACP_ADR_DIGITS 4'h2
`define ACP_LRT_DIGITS 6
`define ACP_NDIG_MAX 4'h5
`define ACP_RX_LAST 3'h7
`define ACP_TX_BITS 4'hA
`endif

// file: pkg/acp_pkg.sv
/*
 * types and line-rate lookups of the ascii command parser.
 * assumes acp_consts.svh is on the include path.
 */
`include "acp_consts.svh"
package acp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_AD1, ST_AD2, ST_CM1, ST_CM2, ST_DATA, ST_SKIP
    } acp_pst_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} acp_rxst_t;

    function automatic logic [16:0] acp_rate_bps(input logic [2:0] i);
        logic [16:0] r;
        unique case (i)
            3'h0: r = `ACP_RATE0;
            3'h1: r = `ACP_RATE1;
            3'h2: r = `ACP_RATE2;
            3'h3: r = `ACP_RATE3;
            3'h4: r = `ACP_RATE4;
            3'h5: r = `ACP_RATE5;
            default: r = 17'h00000;
        endcase
        return r;
    endfunction

    // returns ACP_RATE_N when the value is not a selectable rate
    function automatic logic [2:0] acp_rate_idx(input logic [16:0] v);
        logic [2:0] k;
        k = `ACP_RATE_N;
        for (int i = 0; i < 6; i++) begin
            if (acp_rate_bps(3'(i)) == v) begin
                k = 3'(i);
            end
        end
        return k;
    endfunction
endpackage

// file: test/acp_host_model.sv
/*
 * host side of the serial link: sends command frames and takes
 * reply characters, 7 data bits, even parity, one stop bit.
 * assumes the bench keeps bit_cyc equal to clock cycles per bit.
 */
`timescale 1ns/1ps
module acp_host_model (
    // clock
    input wire logic clk_i,
    // line
    input wire logic rxd_i,
    output logic txd_o
);
    int bit_cyc = 8;
    // rest of the last stop bit, paid before the next start bit
    int owed = 0;

    initial txd_o = 1'b1;

    // ****************************************
    // transmit
    // ****************************************
    // returns as soon as the stop bit begins, so that a prompt
    // reply is never missed by the receiver
    task automatic send_char(input logic [6:0] c);
        logic [9:0] f;
        f = {1'b1, ^c, c, 1'b0};
        repeat (owed) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            #1 txd_o = f[i];
            if (i < 9) begin
                repeat (bit_cyc - 1) @(posedge clk_i);
            end
        end
        owed = bit_cyc - 1;
    endtask

    task automatic send_cmd(input string s);
        byte b;
        send_char(7'h23);
        for (int i = 0; i < s.len(); i++) begin
            b = s[i];
            send_char(b[6:0]);
        end
        send_char(7'h0D);
    endtask

    // ****************************************
    // receive
    // ****************************************
    task automatic recv_char(input int wait_cyc, output logic [6:0] c,
                             output logic ok);
        logic [7:0] d;
        int n;
        ok = 1'b0;
        c = 7'h00;
        for (n = 0; n < wait_cyc && rxd_i !== 1'b0; n++) begin
            @(posedge clk_i);
            #1;
        end
        if (rxd_i !== 1'b0) begin
            return;
        end
        repeat (bit_cyc / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk_i);
            #1 d[i] = rxd_i;
        end
        repeat (bit_cyc) @(posedge clk_i);
        #1;
        c = d[6:0];
        ok = (^d === 1'b0) && (rxd_i === 1'b1);
    endtask
endmodule // acp_host_model

// file: test/acp_parser_tb.sv
/*
 * self-checking bench of the ascii command parser.
 * assumes acp_host_model stands on the serial line as the host.
 */
`timescale 1ns/1ps
module acp_parser_tb;
    // lowered clock figure keeps a character short: 8 cycles per bit
    localparam int CLK_HZ = 153600;
    localparam int LIMIT = 90000;
    logic clk;
    logic rstn;
    logic rxd;
    logic txd;
    logic [6:0] unit_addr;
    logic [2:0] rate_sel;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    int rates[6] = '{1200, 2400, 4800, 9600, 19200, 38400};

    acp_parser #(.CLK_HZ(CLK_HZ)) DUT (
        .CLK_I(clk),
        .RSTN_I(rstn),
        .RXD_I(rxd),
        .TXD_O(txd),
        .UNIT_ADDR_O(unit_addr),
        .RATE_SEL_O(rate_sel)
    );
    acp_host_model u_host (.clk_i(clk), .rxd_i(txd), .txd_o(rxd));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ****************************************
    // compares and helpers
    // ****************************************
    task automatic cmp_val(input string what, input logic [6:0] exp,
                           input logic [6:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // the transmit line must stay high for the whole window
    task automatic cmp_quiet(input int bits);
        int lows;
        lows = 0;
        repeat (bits * u_host.bit_cyc) begin
            @(posedge clk);
            #1 if (txd !== 1'b1) lows++;
        end
        cmp_count++;
        if (lows != 0) begin
            n_mismatch++;
            $display("Error quiet line expected 0 seen %0d", lows);
        end
    endtask

    task automatic expect_reply(input string s);
        logic [6:0] c;
        logic ok;
        byte b;
        for (int i = 0; i < s.len() + 2; i++) begin
            b = (i < s.len()) ? s[i] : ((i == s.len()) ? 8'h0D : 8'h0A);
            u_host.recv_char(40 * u_host.bit_cyc, c, ok);
            cmp_val("reply framing", 7'h01, {6'h00, ok});
            cmp_val("reply char", b[6:0], c);
        end
    endtask

    task automatic set_rate(input int k, input string s);
        u_host.send_cmd({"01br=", s});
        cmp_quiet(15);
        cmp_val("rate select", 7'(k), {4'h0, rate_sel});
        u_host.bit_cyc = CLK_HZ / rates[k];
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        cmp_val("unit address", 7'h01, unit_addr);
        cmp_val("rate select", 7'h04, {4'h0, rate_sel});
        cmp_quiet(20);
    endtask

    task automatic t_read_addr();
        u_host.send_cmd("**AD");
        expect_reply("AD=01");
        u_host.send_cmd("0#01AD");
        expect_reply("AD=01");
    endtask

    task automatic t_write_addr();
        u_host.send_cmd("01ad02");
        cmp_quiet(15);
        cmp_val("unit address", 7'h02, unit_addr);
        u_host.send_cmd("01AD");
        cmp_quiet(15);
        u_host.send_cmd("02AD");
        expect_reply("AD=02");
        u_host.send_cmd("02ad01");
        cmp_quiet(15);
        cmp_val("unit address", 7'h01, unit_addr);
    endtask

    task automatic t_errors();
        u_host.send_cmd("01Ad");
        expect_reply("ER");
        u_host.send_cmd("01ad7");
        expect_reply("ER");
        u_host.send_cmd("01A");
        cmp_quiet(15);
        u_host.send_cmd("01br=12345");
        expect_reply("ER");
        cmp_val("rate select", 7'h04, {4'h0, rate_sel});
    endtask

    // walks every selectable rate, slowest last but one
    task automatic t_rates();
        u_host.send_cmd("01BR");
        expect_reply("BR= 19200");
        set_rate(5, "38400");
        u_host.send_cmd("01BR");
        expect_reply("BR= 38400");
        set_rate(3, " 9600");
        set_rate(2, "4800");
        set_rate(1, "2400");
        set_rate(0, "1200");
        set_rate(4, "19200");
        u_host.send_cmd("01BR");
        expect_reply("BR= 19200");
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        t_reset();
        t_read_addr();
        t_write_addr();
        t_errors();
        t_rates();
        report_and_stop();
    end
endmodule // acp_parser_tb

// file: verilog/acp_parser.sv
/*
 * ascii command interpreter: address and line-rate read and write.
 * assumes a host that sends one command at a time and waits for replies.
 */
`timescale 1ns/1ps
`include "acp_consts.svh"
// How it works
// R1: characters are 7 data bits, even parity, one stop bit, no flow control.
// R2: a pound character received without parity or stop-bit error always starts a new command frame.
// R3: two address digits follow and are compared with the stored address.
// R4: two asterisks in the address position match any address.
// R5: upper-case mnemonic means read, lower-case with data means write.
// R6: nothing is acted upon until the carriage return arrives.
// R7: every reply is printable characters (letters, digits, equals, space) and ends with carriage return, line feed.
// R8: after reset the address is 01 and the rate is 19200.
// R9: address read answers mnemonic, equals, two digits; seven characters.
// R10: a valid address write stores the new address for later frames.
// R11: rate read answers mnemonic, equals, six-wide padded rate; eleven chars.
// R12: a valid rate write switches the line rate at once.
// R13: only 1200, 2400, 4800, 9600, 19200, 38400 are accepted.
// R14: reads always reply; writes reply only with an error, on bad syntax or on a value out of range.
// R15: the transmitter only ever answers a received command.
// R16: frames for another address are dropped without any reply.
module acp_parser #(
    parameter int CLK_HZ = `ACP_CLK_HZ
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // serial line
    input wire logic RXD_I,
    output logic TXD_O,
    // settings in use
    output logic [6:0] UNIT_ADDR_O,
    output logic [2:0] RATE_SEL_O
);
    function automatic logic is_dig(input logic [6:0] c);
        return c >= `ACP_CH_ZERO && c <= `ACP_CH_NINE;
    endfunction
    function automatic logic [6:0] upper(input logic [6:0] c);
        logic [6:0] u;
        u = c;
        u[`ACP_CASE_POS] = 1'b0;
        return u;
    endfunction
    // one decimal digit of v at power p; leading zeros blank when pad
    function automatic logic [6:0] dgt(input logic [16:0] v, input int p,
                                       input logic pad);
        int w;
        w = int'(v);
        if (pad && p > 0 && w < 10 ** p) begin
            return `ACP_CH_SP;
        end
        return `ACP_CH_ZERO + 7'((w / (10 ** p)) % 10);
    endfunction

    acp_pkg::acp_pst_t st_q, st_d;
    logic [6:0] a1_q, a1_d, c0_q, c0_d, c1_q, c1_d;
    logic [16:0] acc_q, acc_d;
    logic [3:0] nd_q, nd_d;
    logic eq_q, eq_d, bad_q, bad_d, exec;
    logic [6:0] addr_q, addr_d, txc_q, txc_d;
    logic [2:0] rate_q, rate_d, ridx;
    logic [6:0] rb_q [`ACP_RB_N];
    logic [6:0] rb_d [`ACP_RB_N];
    logic [3:0] len_q, len_d, idx_q, idx_d;
    logic snd_q, snd_d, go_q, go_d, up_q;
    logic rx_v, rx_e, tx_busy, wr, nodata;
    logic [6:0] rx_ch;

    acp_uart #(.CLK_HZ(CLK_HZ)) u_uart (
        .clk_i(CLK_I),
        .rst_n_i(RSTN_I),
        .rxd_i(RXD_I),
        .txd_o(TXD_O),
        .rate_i(rate_q),
        .rx_valid_o(rx_v),
        .rx_data_o(rx_ch),
        .rx_err_o(rx_e),
        .tx_go_i(go_q),
        .tx_data_i(txc_q),
        .tx_busy_o(tx_busy)
    );

    // ****************************************
    // frame decoding
    // ****************************************
    always_comb begin
        st_d = st_q;
        a1_d = a1_q;
        c0_d = c0_q;
        c1_d = c1_q;
        acc_d = acc_q;
        nd_d = nd_q;
        eq_d = eq_q;
        bad_d = bad_q;
        exec = 1'b0;
        if (rx_v) begin
            if (rx_ch == `ACP_CH_ATTN && !rx_e) begin
                st_d = acp_pkg::ST_AD1; // R2
                acc_d = 17'h00000;
                nd_d = 4'h0;
                eq_d = 1'b0;
                bad_d = 1'b0;
            end else if (rx_ch == `ACP_CH_CR && st_q != acp_pkg::ST_DATA) begin
                st_d = acp_pkg::ST_IDLE;
            end else begin
                bad_d = bad_q | rx_e;
                unique case (st_q)
                    acp_pkg::ST_IDLE: st_d = st_q;
                    acp_pkg::ST_AD1: begin
                        a1_d = rx_ch;
                        st_d = acp_pkg::ST_AD2;
                    end
                    acp_pkg::ST_AD2: begin
                        st_d = acp_pkg::ST_SKIP; // R16
                        if (!bad_d && ((a1_q == `ACP_CH_WILD && // R4
                            rx_ch == `ACP_CH_WILD) || (is_dig(a1_q) &&
                            is_dig(rx_ch) && dgt(17'(addr_q), 1, 1'b0) ==
                            a1_q && dgt(17'(addr_q), 0, 1'b0) == rx_ch))) begin
                            st_d = acp_pkg::ST_CM1; // R3
                        end
                    end
                    acp_pkg::ST_CM1: begin
                        c0_d = rx_ch;
                        st_d = acp_pkg::ST_CM2;
                    end
                    acp_pkg::ST_CM2: begin
                        c1_d = rx_ch;
                        st_d = acp_pkg::ST_DATA;
                    end
                    acp_pkg::ST_DATA: begin
                        if (rx_ch == `ACP_CH_CR) begin
                            exec = 1'b1; // R6
                            st_d = acp_pkg::ST_IDLE;
                        end else if (rx_ch == `ACP_CH_EQ && nd_q == 4'h0 &&
                                     !eq_q) begin
                            eq_d = 1'b1;
                        end else if (rx_ch == `ACP_CH_SP && nd_q == 4'h0) begin
                            eq_d = eq_q;
                        end else if (is_dig(rx_ch) && nd_q != `ACP_NDIG_MAX) begin
                            acc_d = 17'(acc_q * 17'h0000A + 17'(rx_ch -
                                    `ACP_CH_ZERO));
                            nd_d = nd_q + 4'h1;
                        end else begin
                            bad_d = 1'b1;
                        end
                    end
                    acp_pkg::ST_SKIP: st_d = st_q;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_q <= acp_pkg::ST_IDLE;
            a1_q <= 7'h00;
            c0_q <= 7'h00;
            c1_q <= 7'h00;
            acc_q <= 17'h00000;
            nd_q <= 4'h0;
            eq_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            st_q <= st_d;
            a1_q <= a1_d;
            c0_q <= c0_d;
            c1_q <= c1_d;
            acc_q <= acc_d;
            nd_q <= nd_d;
            eq_q <= eq_d;
            bad_q <= bad_d;
        end
    end

    // ****************************************
    // execution and reply
    // ****************************************
    assign wr = c0_q[`ACP_CASE_POS];
    assign nodata = nd_q == 4'h0 && !eq_q && !bad_q;
    assign ridx = acp_pkg::acp_rate_idx(acc_q);

    always_comb begin
        addr_d = addr_q;
        rate_d = rate_q;
        rb_d = rb_q;
        len_d = len_q;
        idx_d = idx_q;
        snd_d = snd_q;
        go_d = 1'b0;
        txc_d = txc_q;
        // a command ending before the last reply character is handed to the transmitter is dropped
        if (exec && !snd_q) begin
            snd_d = 1'b1; // R15
            idx_d = 4'h0;
            len_d = `ACP_LEN_ERR;
            rb_d[0] = `ACP_CMD_ERR0;
            rb_d[1] = `ACP_CMD_ERR1;
            rb_d[2] = `ACP_CH_CR;
            rb_d[3] = `ACP_CH_LF;
            if (c1_q[`ACP_CASE_POS] != wr) begin
                snd_d = 1'b1;
            end else if (upper(c0_q) == `ACP_CMD_ADR0 &&
                         upper(c1_q) == `ACP_CMD_ADR1) begin
                if (!wr && nodata) begin
                    len_d = `ACP_LEN_ADR; // R9
                    rb_d[0] = `ACP_CMD_ADR0;
                    rb_d[1] = `ACP_CMD_ADR1;
                    rb_d[2] = `ACP_CH_EQ;
                    rb_d[3] = dgt(17'(addr_q), 1, 1'b0);
                    rb_d[4] = dgt(17'(addr_q), 0, 1'b0);
                    rb_d[5] = `ACP_CH_CR; // R7
                    rb_d[6] = `ACP_CH_LF;
                end else if (wr && !eq_q && !bad_q && nd_q == `ACP_ADR_DIGITS
                             && acc_q >= `ACP_ADDR_MIN
                             && acc_q <= `ACP_ADDR_MAX) begin
                    addr_d = acc_q[6:0]; // R10
                    snd_d = 1'b0; // R14
                end
            end else if (upper(c0_q) == `ACP_CMD_LRT0 &&
                         upper(c1_q) == `ACP_CMD_LRT1) begin // R5
                if (!wr && nodata) begin
                    len_d = `ACP_LEN_LRT; // R11
                    rb_d[0] = `ACP_CMD_LRT0;
                    rb_d[1] = `ACP_CMD_LRT1;
                    rb_d[2] = `ACP_CH_EQ;
                    for (int i = 0; i < `ACP_LRT_DIGITS; i++) begin
                        rb_d[3 + i] = dgt(acp_pkg::acp_rate_bps(rate_q),
                                          `ACP_LRT_DIGITS - 1 - i, 1'b1);
                    end
                    rb_d[9] = `ACP_CH_CR; // R7
                    rb_d[10] = `ACP_CH_LF;
                end else if (wr && eq_q && !bad_q && ridx != `ACP_RATE_N) begin
                    rate_d = ridx; // R12 R13
                    snd_d = 1'b0; // R14
                end
            end
        end else if (snd_q && !tx_busy && !go_q) begin
            go_d = 1'b1;
            txc_d = rb_q[idx_q];
            idx_d = idx_q + 4'h1;
            if (idx_q == len_q - 4'h1) begin
                snd_d = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            addr_q <= `ACP_ADDR_RST; // R8
            rate_q <= `ACP_RATE_RST;
            for (int i = 0; i < `ACP_RB_N; i++) begin
                rb_q[i] <= 7'h00;
            end
            len_q <= 4'h0;
            idx_q <= 4'h0;
            snd_q <= 1'b0;
            go_q <= 1'b0;
            txc_q <= 7'h00;
            up_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            rate_q <= rate_d;
            rb_q <= rb_d;
            len_q <= len_d;
            idx_q <= idx_d;
            snd_q <= snd_d;
            go_q <= go_d;
            txc_q <= txc_d;
            up_q <= 1'b1;
        end
    end

    assign UNIT_ADDR_O = addr_q;
    assign RATE_SEL_O = rate_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    chk_reset_values: // R8
    assert property (!up_q |-> addr_q == `ACP_ADDR_RST &&
                     rate_q == `ACP_RATE_RST)
    else $error("factory address or rate wrong after reset");
    chk_reply_cause: // R15
    assert property ($rose(snd_q) |-> $past(rx_v && rx_ch == `ACP_CH_CR &&
                     st_q == acp_pkg::ST_DATA))
    else $error("reply started without a terminated command");
    chk_reply_tail: // R7
    assert property (go_q && !snd_q |-> txc_q == `ACP_CH_LF &&
                     rb_q[len_q - 4'h2] == `ACP_CH_CR)
    else $error("reply does not end in carriage return, line feed");
    chk_addr_reply: // R9
    assert property ($rose(snd_q) && rb_q[0] == `ACP_CMD_ADR0 |->
                     len_q == `ACP_LEN_ADR && rb_q[2] == `ACP_CH_EQ)
    else $error("address reply malformed");
    chk_rate_reply: // R11
    assert property ($rose(snd_q) && rb_q[0] == `ACP_CMD_LRT0 |->
                     len_q == `ACP_LEN_LRT && rb_q[2] == `ACP_CH_EQ)
    else $error("rate reply malformed");
    chk_write_quiet: // R14
    assert property ($changed(addr_q) || $changed(rate_q) |-> !snd_q ##1
                     !go_q)
    else $error("write produced a reply");
    chk_drop_foreign: // R16
    assert property (st_q == acp_pkg::ST_SKIP && rx_v |=> !$rose(snd_q))
    else $error("frame for another address was answered");
    chk_legal_settings: // R13
    assert property (rate_q < `ACP_RATE_N && addr_q >= 7'h01 &&
                     addr_q <= 7'h63)
    else $error("stored rate or address out of range");
endmodule // acp_parser

// file: verilog/acp_uart.sv
/*
 * 7 data bits, even parity, one stop bit serial port; no flow control.
 * assumes the receive line is synchronous to the clock and idles high.
 */
`timescale 1ns/1ps
`include "acp_consts.svh"
module acp_uart #(
    parameter int CLK_HZ = `ACP_CLK_HZ
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // line
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic [2:0] rate_i,
    // character side
    output logic rx_valid_o,
    output logic [6:0] rx_data_o,
    output logic rx_err_o,
    input wire logic tx_go_i,
    input wire logic [6:0] tx_data_i,
    output logic tx_busy_o
);
    function automatic logic [19:0] bit_cyc(input logic [2:0] i);
        logic [19:0] c;
        unique case (i)
            3'h0: c = 20'(CLK_HZ / `ACP_RATE0);
            3'h1: c = 20'(CLK_HZ / `ACP_RATE1);
            3'h2: c = 20'(CLK_HZ / `ACP_RATE2);
            3'h3: c = 20'(CLK_HZ / `ACP_RATE3);
            3'h5: c = 20'(CLK_HZ / `ACP_RATE5);
            default: c = 20'(CLK_HZ / `ACP_RATE4);
        endcase
        return c;
    endfunction

    acp_pkg::acp_rxst_t rs_q, rs_d;
    logic [19:0] rc_q, rc_d, tc_q, tc_d, full;
    logic [2:0] rn_q, rn_d;
    logic [7:0] rsh_q, rsh_d;
    logic rv_q, rv_d, re_q, re_d;
    logic [9:0] tsh_q, tsh_d;
    logic [3:0] tn_q, tn_d;

    assign full = bit_cyc(rate_i);

    // ****************************************
    // receiver and transmitter
    // ****************************************
    always_comb begin
        rs_d = rs_q;
        rc_d = rc_q - 20'h00001;
        rn_d = rn_q;
        rsh_d = rsh_q;
        rv_d = 1'b0;
        re_d = re_q;
        unique case (rs_q)
            acp_pkg::RX_IDLE: if (!rxd_i) begin
                rs_d = acp_pkg::RX_START;
                // reload one short: the cycle at zero counts as well
                rc_d = (full >> 1) - 20'h00001;
            end
            acp_pkg::RX_START: if (rc_q == 20'h00000) begin
                // a glitch shorter than half a bit is not a start
                rs_d = rxd_i ? acp_pkg::RX_IDLE : acp_pkg::RX_BITS;
                rc_d = full - 20'h00001;
                rn_d = 3'h0;
            end
            acp_pkg::RX_BITS: if (rc_q == 20'h00000) begin
                rsh_d = {rxd_i, rsh_q[7:1]};
                rn_d = rn_q + 3'h1;
                // one bit time per sample, else slow clocks drift a bit
                rc_d = full - 20'h00001;
                if (rn_q == `ACP_RX_LAST) begin
                    rs_d = acp_pkg::RX_STOP;
                end
            end
            acp_pkg::RX_STOP: if (rc_q == 20'h00000) begin
                rs_d = acp_pkg::RX_IDLE;
                rv_d = 1'b1;
                re_d = (^rsh_q) | !rxd_i; // R1
            end
        endcase
        tsh_d = tsh_q;
        tn_d = tn_q;
        tc_d = tc_q - 20'h00001;
        if (tn_q == 4'h0) begin
            if (tx_go_i) begin
                tsh_d = {1'b1, ^tx_data_i, tx_data_i, 1'b0}; // R1
                tn_d = `ACP_TX_BITS;
                tc_d = full;
            end
        end else if (tc_q == 20'h00001) begin
            tsh_d = {1'b1, tsh_q[9:1]};
            tn_d = tn_q - 4'h1;
            tc_d = full;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rs_q <= acp_pkg::RX_IDLE;
            rc_q <= 20'h00000;
            rn_q <= 3'h0;
            rsh_q <= 8'h00;
            rv_q <= 1'b0;
            re_q <= 1'b0;
            tsh_q <= 10'h3FF;
            tn_q <= 4'h0;
            tc_q <= 20'h00000;
        end else begin
            rs_q <= rs_d;
            rc_q <= rc_d;
            rn_q <= rn_d;
            rsh_q <= rsh_d;
            rv_q <= rv_d;
            re_q <= re_d;
            tsh_q <= tsh_d;
            tn_q <= tn_d;
            tc_q <= tc_d;
        end
    end

    assign txd_o = tsh_q[0];
    assign tx_busy_o = tn_q != 4'h0;
    assign rx_valid_o = rv_q;
    assign rx_data_o = rsh_q[6:0];
    assign rx_err_o = re_q;

    // ****************************************
    // checks
    // ****************************************
    sequence s_go;
        tx_go_i && tn_q == 4'h0;
    endsequence
    sequence s_start_bit;
        !tsh_q[0] && tn_q == `ACP_TX_BITS && tsh_q[9];
    endsequence
    chk_tx_frame: // R1
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_go |=> s_start_bit)
    else $error("transmit frame not started with start bit and stop bit");
endmodule // acp_uart
